// ### verilog/ubrg_top.sv
// Baud rate generator with receive status flags behind an AXI4-Lite register slave.
// Operation
// - One 8-bit baud timer serves asynchronous and synchronous operation.
// - Timer runs continuously while the serial port is enabled; its period comes from the baud divisor.
// - Asynchronous mode: high-speed select picks the period multiplier.
// - Synchronous mode ignores the high-speed select bit.
// - Rate is Fosc/64(n+1), Fosc/16(n+1) or Fosc/4(n+1).
// - Any divisor write clears the timer at once.
// - 9-bit without address detect accepts all bytes; 8-bit ignores address detect.
// - Framing error set on bad stop bit, updated with the next received byte.
// - Overrun set when data is lost; cleared only by clearing continuous receive.
// - Serial port enable clear holds the port logic in reset; set hands over pins.
// - 9-bit with address detect loads and interrupts only when ninth bit is set.
`timescale 1ns/1ps
module ubrg_top import ubrg_pkg::*; #(
  parameter int DW = 8
) (
  input  wire logic          mclk,          // System clock, 50 MHz.
  input  wire logic          arst_n,        // Asynchronous reset, active low.
  input  wire logic [4:0]    s_awaddr,      // Write address.
  input  wire logic          s_awvalid,     // Write address valid.
  output logic               s_awready,     // Write address ready.
  input  wire logic [31:0]   s_wdata,       // Write data.
  input  wire logic [3:0]    s_wstrb,       // Write byte strobes.
  input  wire logic          s_wvalid,      // Write data valid.
  output logic               s_wready,      // Write data ready.
  output logic [1:0]         s_bresp,       // Write response.
  output logic               s_bvalid,      // Write response valid.
  input  wire logic          s_bready,      // Write response ready.
  input  wire logic [4:0]    s_araddr,      // Read address.
  input  wire logic          s_arvalid,     // Read address valid.
  output logic               s_arready,     // Read address ready.
  output logic [31:0]        s_rdata,       // Read data.
  output logic [1:0]         s_rresp,       // Read response.
  output logic               s_rvalid,      // Read data valid.
  input  wire logic          s_rready,      // Read data ready.
  input  wire logic          rx_char_done,  // Receiver finished a character, one-cycle pulse.
  input  wire logic [DW-1:0] rx_char,       // Character data bits.
  input  wire logic          rx_bit8,       // Ninth received bit.
  input  wire logic          rx_stop_ok,    // Stop bit of the character was valid.
  input  wire logic          tx_shift_empty,// Transmit shift register empty.
  output logic               baud_tick,     // Bit-rate tick.
  output logic               port_pins_en,  // Receive and transmit pins owned by the port.
  output logic               rx_run,        // Receiver enabled.
  output logic               irq            // Level interrupt.
);
  logic [7:0]    rcsc_reg, rcsc_next;
  logic [7:0]    div_reg, div_next;
  logic [7:0]    txsc_reg, txsc_next;
  logic [DW-1:0] rxbuf_reg, rxbuf_next;
  logic          full_reg, full_next;
  logic          framing_error_flag_reg, framing_error_flag_next;
  logic          overrun_error_flag_reg, overrun_error_flag_next;
  logic          r9d_reg, r9d_next;
  logic [UBRG_IRQ_W-1:0] ist_reg, ist_next;
  logic [UBRG_IRQ_W-1:0] imask_reg, imask_next;
  logic          irq_reg, irq_next;
  logic          pins_reg, pins_next;
  logic          rxrun_reg, rxrun_next;
  logic          awh_reg, awh_next;
  logic [4:0]    awa_reg, awa_next;
  logic          wh_reg, wh_next;
  logic [31:0]   wd_reg, wd_next;
  logic          ws_reg, ws_next;
  logic          bv_reg, bv_next;
  logic [1:0]    br_reg, br_next;
  logic          rv_reg, rv_next;
  logic [31:0]   rd_reg, rd_next;
  logic [1:0]    rr_reg, rr_next;
  logic          div_wr;
  logic          serial_port_enable;
  logic          accept;
  logic [UBRG_IRQ_W-1:0] ev;

  // Address decode shared by both channels.
  function automatic logic mapped(input logic [4:0] a);
    if (a == UBRG_OFS_RCSC) begin
      mapped = 1'b1;
    end else if (a == UBRG_OFS_DIV || a == UBRG_OFS_TXSC || a == UBRG_OFS_RXDATA) begin
      mapped = 1'b1;
    end else if (a == UBRG_OFS_ISTAT || a == UBRG_OFS_IMASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  endfunction

  assign serial_port_enable = rcsc_reg[UBRG_RC_SERIAL_PORT_ENABLE];

  ubrg_timer #(
    .W(8)
  ) u_timer (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .run        (serial_port_enable),
    .clear      (div_wr),
    .sync_mode  (txsc_reg[UBRG_TX_SYNC]),
    .high_speed (txsc_reg[UBRG_TX_HIGH_SPEED_SELECT]),
    // The timer reloads in the same cycle as the divisor write, so it must see the new value.
    .divisor    (div_next),
    .tick       (baud_tick)
  );

  always_comb begin
    awh_next = awh_reg;
    awa_next = awa_reg;
    wh_next  = wh_reg;
    wd_next  = wd_reg;
    ws_next  = ws_reg;
    bv_next  = bv_reg;
    br_next  = br_reg;
    rv_next  = rv_reg;
    rd_next  = rd_reg;
    rr_next  = rr_reg;
    rcsc_next  = rcsc_reg;
    div_next   = div_reg;
    txsc_next  = txsc_reg;
    imask_next = imask_reg;
    rxbuf_next = rxbuf_reg;
    full_next  = full_reg;
    framing_error_flag_next  = framing_error_flag_reg;
    overrun_error_flag_next  = overrun_error_flag_reg;
    r9d_next   = r9d_reg;
    ist_next   = ist_reg;
    ev         = '0;
    div_wr     = 1'b0;
    accept     = 1'b0;
    if (s_awvalid && s_awready) begin
      awh_next = 1'b1;
      awa_next = s_awaddr;
    end
    if (s_wvalid && s_wready) begin
      wh_next = 1'b1;
      wd_next = s_wdata;
      ws_next = s_wstrb[0];
    end
    if (s_bvalid && s_bready) begin
      bv_next = 1'b0;
    end
    // Both halves held: perform the write this cycle.
    if (awh_reg && wh_reg && !bv_reg) begin
      awh_next = 1'b0;
      wh_next  = 1'b0;
      bv_next  = 1'b1;
      br_next  = mapped(awa_reg) ? UBRG_RESP_OKAY : UBRG_RESP_DECERR;
      if (ws_reg) begin
        if (awa_reg == UBRG_OFS_RCSC) begin
          rcsc_next = {wd_reg[7:3], 3'h0};
        end else if (awa_reg == UBRG_OFS_DIV) begin
          div_next = wd_reg[7:0];
          div_wr   = 1'b1;
        end else if (awa_reg == UBRG_OFS_TXSC) begin
          txsc_next = {wd_reg[7:4], 1'b0, wd_reg[2], 1'b0, wd_reg[0]};
        end else if (awa_reg == UBRG_OFS_ISTAT) begin
          ist_next = ist_reg & ~wd_reg[UBRG_IRQ_W-1:0];
        end else if (awa_reg == UBRG_OFS_IMASK) begin
          imask_next = wd_reg[UBRG_IRQ_W-1:0];
        end
      end
    end
    if (s_rvalid && s_rready) begin
      rv_next = 1'b0;
    end
    if (s_arvalid && s_arready) begin
      rv_next = 1'b1;
      rr_next = mapped(s_araddr) ? UBRG_RESP_OKAY : UBRG_RESP_DECERR;
      rd_next = 32'h0000_0000;
      if (s_araddr == UBRG_OFS_RCSC) begin
        rd_next[7:0] = {rcsc_reg[7:3], framing_error_flag_reg, overrun_error_flag_reg, r9d_reg};
      end else if (s_araddr == UBRG_OFS_DIV) begin
        rd_next[7:0] = div_reg;
      end else if (s_araddr == UBRG_OFS_TXSC) begin
        rd_next[7:0] = {txsc_reg[7:2], tx_shift_empty, txsc_reg[0]};
      end else if (s_araddr == UBRG_OFS_RXDATA) begin
        rd_next[DW-1:0] = rxbuf_reg;
        full_next       = 1'b0;
      end else if (s_araddr == UBRG_OFS_ISTAT) begin
        rd_next[UBRG_IRQ_W-1:0] = ist_reg;
      end else if (s_araddr == UBRG_OFS_IMASK) begin
        rd_next[UBRG_IRQ_W-1:0] = imask_reg;
      end
    end
    // A character counts only with the port and receiver on.
    if (rx_char_done && serial_port_enable && rcsc_reg[UBRG_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
      // Address detect acts only in 9-bit reception.
      if (rcsc_reg[UBRG_RC_RX9] && rcsc_reg[UBRG_RC_ADDRESS_DETECT_ENABLE]) begin
        accept = rx_bit8;
      end else begin
        accept = 1'b1;
      end
    end
    if (accept) begin
      if (full_reg || overrun_error_flag_reg) begin
        overrun_error_flag_next            = 1'b1;
        ev[UBRG_IRQ_OVERRUN_ERROR_FLAG]    = 1'b1;
      end else begin
        rxbuf_next           = rx_char;
        full_next            = 1'b1;
        framing_error_flag_next            = !rx_stop_ok;
        r9d_next             = rcsc_reg[UBRG_RC_RX9] ? rx_bit8 : 1'b0;
        ev[UBRG_IRQ_RXLOAD]  = 1'b1;
        ev[UBRG_IRQ_FRAMING_ERROR_FLAG]    = !rx_stop_ok;
      end
    end
    if (!rcsc_reg[UBRG_RC_CONTINUOUS_RECEIVE_ENABLE]) begin
      overrun_error_flag_next = 1'b0;
    end
    if (!serial_port_enable) begin
      // The port is held in reset, but overrun only clears with the receiver enable.
      full_next = 1'b0;
      framing_error_flag_next = 1'b0;
    end
    // Set wins over a simultaneous write-one-to-clear.
    ist_next = ist_next | ev;
  end

  always_comb begin
    irq_next   = |(ist_next & imask_next);
    pins_next  = rcsc_next[UBRG_RC_SERIAL_PORT_ENABLE];
    rxrun_next = rcsc_next[UBRG_RC_SERIAL_PORT_ENABLE] & rcsc_next[UBRG_RC_CONTINUOUS_RECEIVE_ENABLE];
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awh_reg   <= 1'b0;
      awa_reg   <= 5'h00;
      wh_reg    <= 1'b0;
      wd_reg    <= 32'h0000_0000;
      ws_reg    <= 1'b0;
      bv_reg    <= 1'b0;
      br_reg    <= UBRG_RESP_OKAY;
      rv_reg    <= 1'b0;
      rd_reg    <= 32'h0000_0000;
      rr_reg    <= UBRG_RESP_OKAY;
      rcsc_reg  <= UBRG_RCSC_RST;
      div_reg   <= UBRG_DIV_RST;
      txsc_reg  <= UBRG_TXSC_RST;
      imask_reg <= UBRG_IMASK_RST;
      rxbuf_reg <= '0;
      full_reg  <= 1'b0;
      framing_error_flag_reg  <= 1'b0;
      overrun_error_flag_reg  <= 1'b0;
      r9d_reg   <= 1'b0;
      ist_reg   <= '0;
      irq_reg   <= 1'b0;
      pins_reg  <= 1'b0;
      rxrun_reg <= 1'b0;
    end else begin
      awh_reg   <= awh_next;
      awa_reg   <= awa_next;
      wh_reg    <= wh_next;
      wd_reg    <= wd_next;
      ws_reg    <= ws_next;
      bv_reg    <= bv_next;
      br_reg    <= br_next;
      rv_reg    <= rv_next;
      rd_reg    <= rd_next;
      rr_reg    <= rr_next;
      rcsc_reg  <= rcsc_next;
      div_reg   <= div_next;
      txsc_reg  <= txsc_next;
      imask_reg <= imask_next;
      rxbuf_reg <= rxbuf_next;
      full_reg  <= full_next;
      framing_error_flag_reg  <= framing_error_flag_next;
      overrun_error_flag_reg  <= overrun_error_flag_next;
      r9d_reg   <= r9d_next;
      ist_reg   <= ist_next;
      irq_reg   <= irq_next;
      pins_reg  <= pins_next;
      rxrun_reg <= rxrun_next;
    end
  end

  // Ready flags are plain decodes of holding flops, so they change only after a clock edge.
  assign s_awready    = !awh_reg && !bv_reg;
  assign s_wready     = !wh_reg && !bv_reg;
  assign s_bvalid     = bv_reg;
  assign s_bresp      = br_reg;
  assign s_arready    = !rv_reg;
  assign s_rvalid     = rv_reg;
  assign s_rdata      = rd_reg;
  assign s_rresp      = rr_reg;
  assign port_pins_en = pins_reg;
  assign rx_run       = rxrun_reg;
  assign irq          = irq_reg;
endmodule

// ### verilog/ubrg_pkg.sv
// Package with register map, field positions, reset values and counts of the baud rate generator.
package ubrg_pkg;
  localparam int          UBRG_AW          = 5;
  localparam logic [4:0]  UBRG_OFS_RCSC    = 5'h00;
  localparam logic [4:0]  UBRG_OFS_DIV     = 5'h04;
  localparam logic [4:0]  UBRG_OFS_TXSC    = 5'h08;
  localparam logic [4:0]  UBRG_OFS_RXDATA  = 5'h0c;
  localparam logic [4:0]  UBRG_OFS_ISTAT   = 5'h10;
  localparam logic [4:0]  UBRG_OFS_IMASK   = 5'h14;
  // Receive status and control fields.
  localparam int          UBRG_RC_SERIAL_PORT_ENABLE     = 7;
  localparam int          UBRG_RC_RX9      = 6;
  localparam int          UBRG_RC_SINGLE_RECEIVE_ENABLE     = 5;
  localparam int          UBRG_RC_CONTINUOUS_RECEIVE_ENABLE     = 4;
  localparam int          UBRG_RC_ADDRESS_DETECT_ENABLE    = 3;
  localparam int          UBRG_RC_FRAMING_ERROR_FLAG     = 2;
  localparam int          UBRG_RC_OVERRUN_ERROR_FLAG     = 1;
  localparam int          UBRG_RC_RECEIVED_NINTH_BIT     = 0;
  // Transmit status and control fields.
  localparam int          UBRG_TX_CLOCK_SOURCE_SELECT     = 7;
  localparam int          UBRG_TX_TX9      = 6;
  localparam int          UBRG_TX_TRANSMIT_ENABLE     = 5;
  localparam int          UBRG_TX_SYNC     = 4;
  localparam int          UBRG_TX_HIGH_SPEED_SELECT     = 2;
  localparam int          UBRG_TX_TRANSMIT_SHIFT_EMPTY     = 1;
  localparam int          UBRG_TX_TRANSMIT_NINTH_BIT     = 0;
  // Interrupt status bits.
  localparam int          UBRG_IRQ_RXLOAD  = 0;
  localparam int          UBRG_IRQ_FRAMING_ERROR_FLAG    = 1;
  localparam int          UBRG_IRQ_OVERRUN_ERROR_FLAG    = 2;
  localparam int          UBRG_IRQ_W       = 3;
  // Reset values.
  localparam logic [7:0]  UBRG_RCSC_RST    = 8'h00;
  localparam logic [7:0]  UBRG_DIV_RST     = 8'h00;
  localparam logic [7:0]  UBRG_TXSC_RST    = 8'h00;
  localparam logic [2:0]  UBRG_IMASK_RST   = 3'h0;
  // Prescale counts, one less than the clock multiplier.
  localparam logic [5:0]  UBRG_PRE_ASYNC_LO = 6'h3f;
  localparam logic [5:0]  UBRG_PRE_ASYNC_HI = 6'h0f;
  localparam logic [5:0]  UBRG_PRE_SYNC     = 6'h03;
  localparam logic [1:0]  UBRG_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  UBRG_RESP_DECERR = 2'h3;
endpackage

// ### verilog/ubrg_timer.sv
// Prescaler and reloading 8-bit baud timer that emits one tick per bit-rate period.
`timescale 1ns/1ps
module ubrg_timer import ubrg_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic         mclk,        // System clock.
  input  wire logic         arst_n,      // Asynchronous reset, active low.
  input  wire logic         run,         // Serial port enabled.
  input  wire logic         clear,       // Divisor write strobe.
  input  wire logic         sync_mode,   // Synchronous operation selected.
  input  wire logic         high_speed,  // High-speed select.
  input  wire logic [W-1:0] divisor,     // Reload value n.
  output logic              tick         // One-cycle bit-rate tick.
);
  logic [5:0]   pre_reg, pre_next;
  logic [W-1:0] cnt_reg, cnt_next;
  logic         tick_reg, tick_next;
  logic [5:0]   pre_top;

  always_comb begin
    // Synchronous mode ignores the high-speed bit.
    if (sync_mode) begin
      pre_top = UBRG_PRE_SYNC;
    end else if (high_speed) begin
      pre_top = UBRG_PRE_ASYNC_HI;
    end else begin
      pre_top = UBRG_PRE_ASYNC_LO;
    end
    pre_next  = pre_reg;
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run || clear) begin
      pre_next = 6'h00;
      cnt_next = divisor;
    end else if (pre_reg >= pre_top) begin
      pre_next = 6'h00;
      if (cnt_reg == '0) begin
        cnt_next  = divisor;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 1'b1;
      end
    end else begin
      pre_next = pre_reg + 6'h01;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg  <= 6'h00;
      cnt_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg  <= pre_next;
      cnt_reg  <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// ### verif/ubrg_chk_sva.sv
// Checker for the register slave handshakes and the baud tick outputs.
`timescale 1ns/1ps
module ubrg_chk_sva import ubrg_pkg::*; (
  input wire logic        mclk,         // Clock.
  input wire logic        arst_n,       // Reset, active low.
  input wire logic        s_awvalid,    // Write address valid.
  input wire logic        s_awready,    // Write address ready.
  input wire logic        s_wvalid,     // Write data valid.
  input wire logic        s_wready,     // Write data ready.
  input wire logic        s_bvalid,     // Write response valid.
  input wire logic [4:0]  s_araddr,     // Read address.
  input wire logic        s_arvalid,    // Read address valid.
  input wire logic        s_arready,    // Read address ready.
  input wire logic [31:0] s_rdata,      // Read data.
  input wire logic [1:0]  s_rresp,      // Read response.
  input wire logic        s_rvalid,     // Read data valid.
  input wire logic        baud_tick,    // Bit-rate tick.
  input wire logic        port_pins_en, // Port owns the pins.
  input wire logic        rx_run,       // Receiver enabled.
  input wire logic        irq           // Interrupt.
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  chk_tick_idle: assert property ((!port_pins_en) [*2] |-> !baud_tick)
    else $error("tick while port disabled");
  chk_tick_pulse: assert property (baud_tick |=> (!baud_tick) [*3])
    else $error("ticks closer than four clocks");
  chk_run_port: assert property (rx_run |-> port_pins_en)
    else $error("receiver runs with port disabled");
  chk_aw_refuse: assert property (s_bvalid |-> !s_awready && !s_wready)
    else $error("write taken while response pending");
  chk_ar_refuse: assert property (s_rvalid |-> !s_arready)
    else $error("read taken while data pending");
  chk_rdata_upper: assert property (s_rvalid |-> s_rdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  chk_write_answer: assert property (s_awvalid && s_awready && s_wvalid && s_wready |-> ##2 s_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
    else $error("read data late");
  chk_read_decerr: assert property (s_arvalid && s_arready && s_araddr > UBRG_OFS_IMASK
    |=> s_rresp == UBRG_RESP_DECERR && s_rdata == 32'h0)
    else $error("unmapped read not refused");
  cov_tick: cover property (baud_tick);
  cov_irq: cover property ($rose(irq));
  cov_decerr: cover property (s_rvalid && s_rresp == UBRG_RESP_DECERR);
endmodule

// ### verif/ubrg_remote.sv
// Remote serial device model that hands finished characters to the receiver.
`timescale 1ns/1ps
module ubrg_remote (
  input  wire logic       mclk,        // Clock.
  input  wire logic       send,        // Deliver request, one cycle.
  input  wire logic [7:0] char_in,     // Character to deliver.
  input  wire logic       bit8_in,     // Ninth bit to deliver.
  input  wire logic       stop_ok_in,  // Stop bit good.
  output logic            char_done,   // Character finished pulse.
  output logic      [7:0] char_out,    // Character bits.
  output logic            bit8_out,    // Ninth bit.
  output logic            stop_ok_out  // Stop bit good.
);
  // Outside the pulse the lines flip, so stale data never passes for fresh data.
  always @(posedge mclk) begin
    char_done <= send;
    if (send) begin
      {char_out, bit8_out, stop_ok_out} <= {char_in, bit8_in, stop_ok_in};
    end else begin
      {char_out, bit8_out, stop_ok_out} <= ~{char_out, bit8_out, stop_ok_out};
    end
  end
endmodule

// ### verif/tb_uart_baud_rate_generator.sv
// Self-checking bench for the baud rate generator and its receive status flags.
`timescale 1ns/1ps
module tb_uart_baud_rate_generator import ubrg_pkg::*;;
  logic        mclk, arst_n, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic        s_arvalid, s_arready, s_rvalid, s_rready, rx_char_done, rx_bit8, rx_stop_ok;
  logic        tx_shift_empty, baud_tick, port_pins_en, rx_run, irq, snd, s8, sok;
  logic [4:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, d;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic [7:0]  rx_char, sc, c;
  logic [9:0]  cfg [6];
  int          error_cnt, comparisons, seed, n, k;

  ubrg_top i_ubrg_top (.mclk(mclk), .arst_n(arst_n), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .rx_char_done(rx_char_done), .rx_char(rx_char), .rx_bit8(rx_bit8), .rx_stop_ok(rx_stop_ok),
    .tx_shift_empty(tx_shift_empty), .baud_tick(baud_tick), .port_pins_en(port_pins_en), .rx_run(rx_run),
    .irq(irq));
  ubrg_remote i_ubrg_remote (.mclk(mclk), .send(snd), .char_in(sc), .bit8_in(s8), .stop_ok_in(sok),
    .char_done(rx_char_done), .char_out(rx_char), .bit8_out(rx_bit8), .stop_ok_out(rx_stop_ok));

  task automatic test_done;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  function automatic logic [31:0] resp_of(input logic [4:0] a);
    return 32'(a > UBRG_OFS_IMASK ? UBRG_RESP_DECERR : UBRG_RESP_OKAY);
  endfunction

  function automatic int mult(input logic s, input logic h);
    return s ? 4 : (h ? 16 : 64);
  endfunction

  // The extra two clocks let flags that follow a register update settle before the caller looks.
  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    @(posedge mclk);
    {s_awaddr, s_wdata} <= {a, v};
    {s_awvalid, s_wvalid, s_bready} <= 3'b111;
    forever begin
      @(posedge mclk);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) break;
    end
    s_bready <= 1'b0;
    chk(32'(s_bresp), resp_of(a));
    repeat (2) @(posedge mclk);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    @(posedge mclk);
    s_araddr <= a;
    {s_arvalid, s_rready} <= 2'b11;
    forever begin
      @(posedge mclk);
      if (s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) break;
    end
    s_rready <= 1'b0;
    chk(s_rdata, e);
    chk(32'(s_rresp), resp_of(a));
  endtask

  task automatic rx(input logic b8, input logic ok);
    c = 8'($random(seed));
    {snd, sc, s8, sok} <= {1'b1, c, b8, ok};
    @(posedge mclk);
    snd <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask

  task automatic tk(output int cnt);
    cnt = 0;
    do begin
      @(posedge mclk);
      cnt++;
    end while (baud_tick !== 1'b1);
  endtask

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  initial begin
    repeat (100000) @(posedge mclk);
    error_cnt++;
    test_done;
  end

  initial begin
    seed = 32'ha7feaf31;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, snd, s8, sok, arst_n} = '0;
    {s_awaddr, s_araddr, s_wdata, sc} = '0;
    s_wstrb = 4'hf;
    tx_shift_empty = 1'($random(seed));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    for (int a = 0; a < 6; a++) rdc(5'(a * 4), (a == 2) ? {30'h0, tx_shift_empty, 1'b0} : 32'h0);
    rdc(5'h18, 32'h0);
    wr(5'h1c, 32'hff);
    d = 32'($random(seed)) & 32'hff;
    wr(UBRG_OFS_DIV, d);
    rdc(UBRG_OFS_DIV, d);
    wr(UBRG_OFS_TXSC, 32'hff);
    rdc(UBRG_OFS_TXSC, 32'hf5 | {30'h0, tx_shift_empty, 1'b0});
    wr(UBRG_OFS_RCSC, 32'hff);
    rdc(UBRG_OFS_RCSC, 32'hf8);
    cfg = '{10'h000, 10'h100, 10'h200, 10'h3ff, 10'h100, 10'h000};
    for (int i = 0; i < 6; i++) begin
      n = (i % 2 == 0) ? ($random(seed) & 15) : int'(cfg[i][7:0]);
      wr(UBRG_OFS_TXSC, 32'({cfg[i][9], 1'b0, cfg[i][8], 2'h0}));
      wr(UBRG_OFS_DIV, 32'hff);
      repeat (9) @(posedge mclk);
      wr(UBRG_OFS_DIV, 32'(n));
      tk(k);
      chk(32'(k <= mult(cfg[i][9], cfg[i][8]) * (n + 1) + 3), 32'h1);
      tk(k);
      chk(32'(k), 32'(mult(cfg[i][9], cfg[i][8]) * (n + 1)));
    end
    wr(UBRG_OFS_RCSC, 32'h00);
    chk(32'({port_pins_en, rx_run}), 32'h0);
    k = 0;
    repeat (300) begin
      @(posedge mclk);
      k += int'(baud_tick);
    end
    chk(32'(k), 32'h0);
    wr(UBRG_OFS_IMASK, 32'h7);
    wr(UBRG_OFS_RCSC, 32'h90);
    chk(32'({port_pins_en, rx_run}), 32'h3);
    rx(1'b0, 1'b1);
    chk(32'(irq), 32'h1);
    rdc(UBRG_OFS_ISTAT, 32'h1);
    rdc(UBRG_OFS_RXDATA, 32'(c));
    wr(UBRG_OFS_ISTAT, 32'h7);
    chk(32'(irq), 32'h0);
    rx(1'b0, 1'b0);
    rdc(UBRG_OFS_RCSC, 32'h94);
    rdc(UBRG_OFS_RXDATA, 32'(c));
    rx(1'b0, 1'b1);
    rdc(UBRG_OFS_RCSC, 32'h90);
    rdc(UBRG_OFS_RXDATA, 32'(c));
    rx(1'b0, 1'b1);
    d = 32'(c);
    rx(1'b0, 1'b1);
    rdc(UBRG_OFS_RCSC, 32'h92);
    rdc(UBRG_OFS_RXDATA, d);
    wr(UBRG_OFS_IMASK, 32'h0);
    chk(32'(irq), 32'h0);
    rdc(UBRG_OFS_RCSC, 32'h92);
    wr(UBRG_OFS_RCSC, 32'h80);
    rdc(UBRG_OFS_RCSC, 32'h80);
    wr(UBRG_OFS_ISTAT, 32'h7);
    wr(UBRG_OFS_IMASK, 32'h7);
    wr(UBRG_OFS_RCSC, 32'hd8);
    rx(1'b0, 1'b1);
    chk(32'(irq), 32'h0);
    rdc(UBRG_OFS_ISTAT, 32'h0);
    rx(1'b1, 1'b1);
    rdc(UBRG_OFS_RCSC, 32'hd9);
    rdc(UBRG_OFS_RXDATA, 32'(c));
    wr(UBRG_OFS_RCSC, 32'hd0);
    rx(1'b0, 1'b1);
    rdc(UBRG_OFS_RCSC, 32'hd0);
    rdc(UBRG_OFS_RXDATA, 32'(c));
    wr(UBRG_OFS_RCSC, 32'h98);
    rx(1'b1, 1'b1);
    rdc(UBRG_OFS_RCSC, 32'h98);
    rdc(UBRG_OFS_RXDATA, 32'(c));
    test_done;
  end
endmodule

bind ubrg_top ubrg_chk_sva i_ubrg_chk_sva (.mclk(mclk), .arst_n(arst_n), .s_awvalid(s_awvalid),
  .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bvalid(s_bvalid), .s_araddr(s_araddr),
  .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
  .baud_tick(baud_tick), .port_pins_en(port_pins_en), .rx_run(rx_run), .irq(irq));
